// >>> inc/hse_pkg.sv
// Constants and types shared by the hub status LED encoder.
// Function
// - Supply LED: off, flash green, steady green.
// - Mode LED follows init, run, wait, standby, isolation.
// - Input LED shows short, standby, isolation, both.
// - Each Ethernet LED: off, link green, traffic flashing.
// - System LED: off, green flash fault, red failure.
// - Wireless LED off standalone, green in wireless.
// - Pairing flashes system and wireless red together; a component failure keeps system steady red.
// - Regulator LED slow green without IO-Link device.
// - Regulator LED fast green on device errors.
// - Regulator LED steady green while device communicates.
// - Regulator LED steady red on port short.
// - Switched regulator output shows orange or off.
// - Standby port LED: off, orange, red short.
package hse_pkg;

  // Timing.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int TICK_PERIOD_NS   = 1000000;
  localparam int TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_SEC    = 1000;
  localparam int FAST_FLASH_HZ    = 2;
  localparam int HALF_TICKS       = TICKS_PER_SEC / (2 * FAST_FLASH_HZ);

  // Colour codes: orange lights both dies.
  localparam logic [1:0] COL_OFF = 2'h0;
  localparam logic [1:0] COL_GRN = 2'h1;
  localparam logic [1:0] COL_RED = 2'h2;
  localparam logic [1:0] COL_ORG = 2'h3;

  typedef enum logic [1:0] {PAT_STEADY, PAT_SLOW, PAT_FAST} hse_pat_e;

  typedef enum logic [2:0] {
    OP_INIT, OP_RUN, OP_WAIT_SB, OP_STANDBY, OP_ISOLATE
  } hse_op_e;

  // LED indices.
  localparam int NLED     = 10;
  localparam int LED_SUP  = 0;
  localparam int LED_OP   = 1;
  localparam int LED_INP  = 2;
  localparam int LED_ETH0 = 3;
  localparam int NETH     = 2;
  localparam int LED_SYS  = 5;
  localparam int LED_SAW  = 6;
  localparam int LED_VLV  = 7;
  localparam int LED_REG  = 8;
  localparam int LED_SBP  = 9;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_MASK = 12'h008;
  localparam logic [11:0] OFS_LEDS = 12'h00c;

  // Fields.
  localparam int CTRL_SWITCHED = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int NEVT          = 8;
  localparam logic [7:0] EVT_RST = 8'h00;
  localparam int EVT_SUP_ABN   = 0;
  localparam int EVT_IN_SHORT  = 1;
  localparam int EVT_OUT_SHORT = 2;
  localparam int EVT_COMP_FAIL = 3;
  localparam int EVT_VLV_SHORT = 4;
  localparam int EVT_REG_SHORT = 5;
  localparam int EVT_REG_ERR   = 6;
  localparam int EVT_SBP_SHORT = 7;
  localparam int LEDS_GRN_LSB  = 0;
  localparam int LEDS_RED_LSB  = 16;

endpackage

// >>> testbench/hse_led_viewer.sv
// Operator model: what an eye sees on each front-panel LED over a window.
`timescale 1ns/10ps
module hse_led_viewer (
  // System
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Window restart
  input  wire logic        clr,
  // LED dies
  input  wire logic [9:0]  led_grn,
  input  wire logic [9:0]  led_red,
  // Seen since restart; period_q ignores restarts
  output logic [9:0]       seen_grn_q,
  output logic [9:0]       seen_red_q,
  output logic [9:0]       blink_q,
  output logic             split_q,
  output logic [15:0]      period_q
);
  logic [9:0]  grn_q;
  logic [9:0]  red_q;
  logic [15:0] cnt_q;

  // The period counter ignores restarts, so one window yields a full cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grn_q      <= 10'h000;
      red_q      <= 10'h000;
      seen_grn_q <= 10'h000;
      seen_red_q <= 10'h000;
      blink_q    <= 10'h000;
      split_q    <= 1'b0;
      cnt_q      <= 16'h0000;
      period_q   <= 16'h0000;
    end
    else
    begin
      grn_q <= led_grn;
      red_q <= led_red;
      seen_grn_q <= clr ? 10'h000 : seen_grn_q | led_grn;
      seen_red_q <= clr ? 10'h000 : seen_red_q | led_red;
      blink_q <= clr ? 10'h000
                     : blink_q | (led_grn ^ grn_q) | (led_red ^ red_q);
      split_q <= clr ? 1'b0 : split_q | (led_red[5] ^ led_red[6]);
      cnt_q <= (led_grn[8] && !grn_q[8]) ? 16'h0001 : cnt_q + 16'h0001;
      if (led_grn[8] && !grn_q[8])
        period_q <= cnt_q;
    end
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the hub status LED encoder.
`timescale 1ns/10ps
module testbench;
  localparam int TK = 4;
  localparam int FAST_PER = 2 * hse_pkg::HALF_TICKS * TK;
  localparam int SLOW_PER = 2 * FAST_PER;
  localparam logic [1:0] D = hse_pkg::COL_OFF;
  localparam logic [1:0] G = hse_pkg::COL_GRN;
  localparam logic [1:0] R = hse_pkg::COL_RED;
  localparam logic [1:0] O = hse_pkg::COL_ORG;

  logic            clk = 1'b0, rst_n = 1'b0, clr = 1'b0;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0;
  logic            supply_present = 1'b1, supply_abnormal = 1'b0;
  logic [2:0]      op_state = 3'h1;
  logic            standby_in = 1'b0, isolation_in = 1'b0, input_short = 1'b0;
  logic [1:0]      eth_link = 2'h0, eth_act = 2'h0;
  logic            remote_type = 1'b1, output_short = 1'b0, pairing = 1'b0;
  logic            component_fail = 1'b0, wireless_mode = 1'b0;
  logic            supply_valve_output = 1'b0, valve_short = 1'b0;
  logic            reg_dev_connected = 1'b1, reg_dev_comm = 1'b1;
  logic            reg_mismatch = 1'b0, reg_map_err = 1'b0, reg_ds_err = 1'b0;
  logic            reg_short_24v = 1'b0, reg_short_cq = 1'b0;
  logic            regulator_switched_output = 1'b0;
  logic            sb_port_in = 1'b0, sb_port_short = 1'b0;
  logic [31:0]     prdata, rdat, lexp;
  logic            pready, pslverr, irq, rerr, split_q;
  logic [9:0]      led_grn, led_red, seen_grn_q, seen_red_q, blink_q, ef;
  logic [15:0]     period_q;
  logic [9:0][1:0] ec;
  int              err_total = 0;
  int              checked = 0;

  always #5 clk = ~clk;

  hse_led_encoder #(.TICK_CYCLES(TK)) dut (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .supply_present, .supply_abnormal, .op_state,
    .standby_in, .isolation_in, .input_short, .eth_link, .eth_act,
    .remote_type, .output_short, .component_fail, .wireless_mode, .pairing,
    .supply_valve_output, .valve_short, .reg_dev_connected, .reg_dev_comm,
    .reg_mismatch, .reg_map_err, .reg_ds_err, .reg_short_24v, .reg_short_cq,
    .regulator_switched_output, .sb_port_in, .sb_port_short, .led_grn,
    .led_red
  );

  hse_led_viewer viewer (
    .clk, .rst_n, .clr, .led_grn, .led_red, .seen_grn_q, .seen_red_q,
    .blink_q, .split_q, .period_q
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      err_total++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Let the LEDs settle, watch them for cyc cycles, compare with ec and ef.
  task automatic win(input string nm, input int cyc);
    repeat (4) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (cyc) @(posedge clk);
    for (int i = 0; i < hse_pkg::NLED; i++)
    begin
      chk({30'h0, seen_red_q[i], seen_grn_q[i]}, {30'h0, ec[i]});
      chk({31'h0, blink_q[i]}, {31'h0, ef[i]});
    end
    $display("test %s done", nm);
  endtask

  task test_done;
    $display("checks=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #600000;
    err_total++;
    test_done();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, hse_pkg::OFS_CTRL, 32'h0);
    chk(rdat, hse_pkg::CTRL_RST);
    apb(1'b0, hse_pkg::OFS_STAT, 32'h0);
    chk(rdat, {24'h0, hse_pkg::EVT_RST});
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    ec = {D, G, D, D, D, D, D, D, G, G};
    ef = 10'h000;
    win("baseline", 4100);
    @(posedge clk);
    supply_abnormal <= 1'b1;
    op_state <= 3'h2;
    input_short <= 1'b1;
    eth_link <= 2'h3;
    eth_act <= 2'h1;
    wireless_mode <= 1'b1;
    supply_valve_output <= 1'b1;
    reg_mismatch <= 1'b1;
    sb_port_in <= 1'b1;
    ec = {O, G, O, G, G, G, G, G, G, G};
    ef = 10'h12f;
    win("flash", 4100);
    chk({16'h0, period_q}, FAST_PER);
    lexp = (32'h1 << hse_pkg::EVT_SUP_ABN) | (32'h1 << hse_pkg::EVT_REG_ERR);
    apb(1'b0, hse_pkg::OFS_STAT, 32'h0);
    chk(rdat, lexp | (32'h1 << hse_pkg::EVT_IN_SHORT));
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, hse_pkg::OFS_MASK, 32'h1 << hse_pkg::EVT_IN_SHORT);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, hse_pkg::OFS_STAT, 32'h1 << hse_pkg::EVT_IN_SHORT);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, hse_pkg::OFS_STAT, 32'h0);
    chk(rdat, lexp);
    supply_present <= 1'b0;
    op_state <= 3'h3;
    input_short <= 1'b0;
    standby_in <= 1'b1;
    eth_link <= 2'h1;
    eth_act <= 2'h2;
    component_fail <= 1'b1;
    valve_short <= 1'b1;
    reg_short_cq <= 1'b1;
    sb_port_short <= 1'b1;
    ec = {R, R, R, G, R, D, G, G, O, D};
    ef = 10'h000;
    win("faults", 4100);
    lexp = 32'h0;
    for (int i = 0; i < hse_pkg::NLED; i++)
    begin
      lexp[hse_pkg::LEDS_GRN_LSB + i] = ec[i][0];
      lexp[hse_pkg::LEDS_RED_LSB + i] = ec[i][1];
    end
    apb(1'b0, hse_pkg::OFS_LEDS, 32'h0);
    chk(rdat, lexp);
    supply_present <= 1'b1;
    supply_abnormal <= 1'b0;
    op_state <= 3'h4;
    standby_in <= 1'b0;
    isolation_in <= 1'b1;
    eth_link <= 2'h0;
    component_fail <= 1'b0;
    pairing <= 1'b1;
    reg_short_cq <= 1'b0;
    reg_short_24v <= 1'b1;
    ec = {R, R, R, R, R, D, D, O, O, G};
    ef = 10'h066;
    win("pairing", 4100);
    chk({31'h0, split_q}, 32'h0);
    op_state <= 3'h7;
    standby_in <= 1'b1;
    pairing <= 1'b0;
    output_short <= 1'b1;
    wireless_mode <= 1'b0;
    reg_short_24v <= 1'b0;
    reg_mismatch <= 1'b0;
    reg_dev_connected <= 1'b0;
    reg_dev_comm <= 1'b0;
    valve_short <= 1'b0;
    supply_valve_output <= 1'b0;
    sb_port_short <= 1'b0;
    sb_port_in <= 1'b0;
    ec = {D, G, D, D, G, D, D, O, D, G};
    ef = 10'h120;
    win("slow", 8100);
    chk({16'h0, period_q}, SLOW_PER);
    reg_dev_connected <= 1'b1;
    reg_dev_comm <= 1'b1;
    reg_map_err <= 1'b1;
    win("map error", 4100);
    chk({16'h0, period_q}, FAST_PER);
    reg_map_err <= 1'b0;
    reg_ds_err <= 1'b1;
    win("storage error", 4100);
    chk({16'h0, period_q}, FAST_PER);
    apb(1'b1, hse_pkg::OFS_CTRL, 32'h1 << hse_pkg::CTRL_SWITCHED);
    apb(1'b0, hse_pkg::OFS_CTRL, 32'h0);
    chk(rdat, 32'h1 << hse_pkg::CTRL_SWITCHED);
    reg_ds_err <= 1'b0;
    regulator_switched_output <= 1'b1;
    ec = {D, O, D, D, G, D, D, O, D, G};
    ef = 10'h020;
    win("switched on", 4100);
    regulator_switched_output <= 1'b0;
    remote_type <= 1'b0;
    ec = {D, D, D, D, D, D, D, O, D, G};
    ef = 10'h000;
    win("switched off", 4100);
    test_done();
  end
endmodule

// >>> verilog/hse_blink_gen.sv
// Blink phase generator: millisecond enable and two in-phase rates.
`timescale 1ns/10ps
module hse_blink_gen #(
  parameter int TICK_CYCLES = hse_pkg::TICK_CYCLES_DFLT
) (
  // System
  input  wire logic clk,
  input  wire logic rst_n,
  // Phases
  output logic      fast_q,
  output logic      slow_q
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [7:0] HALF_LAST = 8'(hse_pkg::HALF_TICKS - 1);

  logic [TW-1:0] tcnt_q;
  logic [TW-1:0] tcnt_d;
  logic [7:0]    hcnt_q;
  logic [7:0]    hcnt_d;
  logic          tick;
  logic          fast_d;
  logic          slow_d;

  // Slow toggles only as fast falls, so both rates share edges.
  always_comb
  begin
    tick   = (tcnt_q == TICK_LAST);
    tcnt_d = tick ? '0 : tcnt_q + TW'(1);
    hcnt_d = hcnt_q;
    fast_d = fast_q;
    slow_d = slow_q;
    if (tick)
    begin
      hcnt_d = (hcnt_q == HALF_LAST) ? 8'h00 : hcnt_q + 8'h01;
      if (hcnt_q == HALF_LAST)
      begin
        fast_d = !fast_q;
        slow_d = fast_q ? !slow_q : slow_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tcnt_q <= '0;
      hcnt_q <= 8'h00;
      fast_q <= 1'b0;
      slow_q <= 1'b0;
    end
    else
    begin
      tcnt_q <= tcnt_d;
      hcnt_q <= hcnt_d;
      fast_q <= fast_d;
      slow_q <= slow_d;
    end
  end

  chk_fast_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !tick |=> $stable(fast_q))
    else $error("fast phase changed without a tick");

  chk_slow_aligned: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(slow_q) |-> $fell(fast_q))
    else $error("slow phase moved off a fast edge");

endmodule

// >>> verilog/hse_led_drive.sv
// One bicolour LED driver: colour and pattern to registered dies.
`timescale 1ns/10ps
module hse_led_drive (
  // System
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Selection
  input  wire logic [1:0]       colour,
  input  hse_pkg::hse_pat_e     pattern,
  input  wire logic             fast_ph,
  input  wire logic             slow_ph,
  // LED dies
  output logic                  grn_q,
  output logic                  red_q
);

  logic lit;
  logic grn_d;
  logic red_d;

  always_comb
  begin
    case (pattern)
      hse_pkg::PAT_STEADY: lit = 1'b1;
      hse_pkg::PAT_SLOW:   lit = slow_ph;
      hse_pkg::PAT_FAST:   lit = fast_ph;
      default:             lit = 1'b0;
    endcase
    grn_d = lit && colour[0];
    red_d = lit && colour[1];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grn_q <= 1'b0;
      red_q <= 1'b0;
    end
    else
    begin
      grn_q <= grn_d;
      red_q <= red_d;
    end
  end

  chk_steady_colour: assert property (@(posedge clk) disable iff (!rst_n)
    pattern == hse_pkg::PAT_STEADY |=>
      grn_q == $past(colour[0]) && red_q == $past(colour[1]))
    else $error("steady LED does not show its colour");

endmodule

// >>> verilog/hse_led_encoder.sv
// Hub status LED encoder with APB registers and event interrupt.
`timescale 1ns/10ps
module hse_led_encoder #(
  parameter int TICK_CYCLES = hse_pkg::TICK_CYCLES_DFLT
) (
  // System
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Supply and mode
  input  wire logic        supply_present,
  input  wire logic        supply_abnormal,
  input  wire logic [2:0]  op_state,
  // Standby and isolation inputs
  input  wire logic        standby_in,
  input  wire logic        isolation_in,
  input  wire logic        input_short,
  // Ethernet ports
  input  wire logic [1:0]  eth_link,
  input  wire logic [1:0]  eth_act,
  // Remote type
  input  wire logic        remote_type,
  input  wire logic        output_short,
  input  wire logic        component_fail,
  input  wire logic        wireless_mode,
  input  wire logic        pairing,
  // Valve port
  input  wire logic        supply_valve_output,
  input  wire logic        valve_short,
  // Regulator port
  input  wire logic        reg_dev_connected,
  input  wire logic        reg_dev_comm,
  input  wire logic        reg_mismatch,
  input  wire logic        reg_map_err,
  input  wire logic        reg_ds_err,
  input  wire logic        reg_short_24v,
  input  wire logic        reg_short_cq,
  input  wire logic        regulator_switched_output,
  // Standby port
  input  wire logic        sb_port_in,
  input  wire logic        sb_port_short,
  // LED dies
  output logic [9:0]       led_grn,
  output logic [9:0]       led_red
);

  localparam int NL = hse_pkg::NLED;
  function automatic logic [3:0] show(input logic [1:0] c,
                                      input hse_pkg::hse_pat_e p);
    show = {p, c};
  endfunction
  localparam logic [3:0] DARK = 4'h0;
  hse_pkg::hse_op_e op_q;
  hse_pkg::hse_op_e op_d;
  logic [3:0]       sel [NL];
  logic             fast_ph;
  logic             slow_ph;
  logic             reg_short;
  logic             reg_err;
  logic             sw_mode;

  // Register state.
  logic [31:0]      ctrl_q;
  logic [31:0]      ctrl_d;
  logic [7:0]       stat_q;
  logic [7:0]       stat_d;
  logic [7:0]       mask_q;
  logic [7:0]       mask_d;
  logic [7:0]       flt_q;
  logic [7:0]       flt;
  logic [31:0]      rdata_d;
  logic             slverr_d;
  logic             irq_d;
  logic             setup;
  logic             wr;
  logic             hit;

  assign reg_short = reg_short_24v || reg_short_cq;
  assign reg_err   = reg_mismatch || reg_map_err || reg_ds_err;
  assign sw_mode   = ctrl_q[hse_pkg::CTRL_SWITCHED];

  // Undefined mode codes fall back to initialization, the dark state.
  always_comb
  begin
    if (op_state <= 3'(hse_pkg::OP_ISOLATE))
      op_d = hse_pkg::hse_op_e'(op_state);
    else
      op_d = hse_pkg::OP_INIT;
  end

  always_comb
  begin
    for (int i = 0; i < NL; i++)
      sel[i] = DARK;

    if (!supply_present)
      sel[hse_pkg::LED_SUP] = DARK;
    else if (supply_abnormal)
      sel[hse_pkg::LED_SUP] = show(hse_pkg::COL_GRN, hse_pkg::PAT_SLOW);
    else
      sel[hse_pkg::LED_SUP] = show(hse_pkg::COL_GRN, hse_pkg::PAT_STEADY);

    case (op_q)
      hse_pkg::OP_RUN:
        sel[hse_pkg::LED_OP] = show(hse_pkg::COL_GRN, hse_pkg::PAT_STEADY);
      hse_pkg::OP_WAIT_SB:
        sel[hse_pkg::LED_OP] = show(hse_pkg::COL_GRN, hse_pkg::PAT_SLOW);
      hse_pkg::OP_STANDBY:
        sel[hse_pkg::LED_OP] = show(hse_pkg::COL_ORG, hse_pkg::PAT_STEADY);
      hse_pkg::OP_ISOLATE:
        sel[hse_pkg::LED_OP] = show(hse_pkg::COL_ORG, hse_pkg::PAT_SLOW);
      default:
        sel[hse_pkg::LED_OP] = DARK;
    endcase

    // A short outranks whatever the inputs claim.
    if (input_short)
      sel[hse_pkg::LED_INP] = show(hse_pkg::COL_GRN, hse_pkg::PAT_SLOW);
    else if (standby_in && isolation_in)
      sel[hse_pkg::LED_INP] = show(hse_pkg::COL_ORG, hse_pkg::PAT_STEADY);
    else if (isolation_in)
      sel[hse_pkg::LED_INP] = show(hse_pkg::COL_ORG, hse_pkg::PAT_SLOW);
    else if (standby_in)
      sel[hse_pkg::LED_INP] = show(hse_pkg::COL_GRN, hse_pkg::PAT_STEADY);

    for (int p = 0; p < hse_pkg::NETH; p++)
    begin
      if (eth_link[p] && eth_act[p])
        sel[hse_pkg::LED_ETH0 + p] =
          show(hse_pkg::COL_GRN, hse_pkg::PAT_SLOW);
      else if (eth_link[p])
        sel[hse_pkg::LED_ETH0 + p] =
          show(hse_pkg::COL_GRN, hse_pkg::PAT_STEADY);
    end

    // The system and wireless LEDs exist only on the remote hub.
    if (remote_type)
    begin
      if (component_fail)
        sel[hse_pkg::LED_SYS] = show(hse_pkg::COL_RED, hse_pkg::PAT_STEADY);
      else if (pairing)
        sel[hse_pkg::LED_SYS] = show(hse_pkg::COL_RED, hse_pkg::PAT_SLOW);
      else if (supply_abnormal || output_short)
        sel[hse_pkg::LED_SYS] = show(hse_pkg::COL_GRN, hse_pkg::PAT_SLOW);
      if (pairing)
        sel[hse_pkg::LED_SAW] = show(hse_pkg::COL_RED, hse_pkg::PAT_SLOW);
      else if (wireless_mode)
        sel[hse_pkg::LED_SAW] = show(hse_pkg::COL_GRN, hse_pkg::PAT_STEADY);
    end

    if (valve_short)
      sel[hse_pkg::LED_VLV] = show(hse_pkg::COL_RED, hse_pkg::PAT_STEADY);
    else if (supply_valve_output)
      sel[hse_pkg::LED_VLV] = show(hse_pkg::COL_ORG, hse_pkg::PAT_STEADY);

    if (reg_short)
      sel[hse_pkg::LED_REG] = show(hse_pkg::COL_RED, hse_pkg::PAT_STEADY);
    else if (sw_mode)
    begin
      if (regulator_switched_output)
        sel[hse_pkg::LED_REG] = show(hse_pkg::COL_ORG, hse_pkg::PAT_STEADY);
    end
    else if (!reg_dev_connected)
      sel[hse_pkg::LED_REG] = show(hse_pkg::COL_GRN, hse_pkg::PAT_SLOW);
    else if (reg_err)
      sel[hse_pkg::LED_REG] = show(hse_pkg::COL_GRN, hse_pkg::PAT_FAST);
    else if (reg_dev_comm)
      sel[hse_pkg::LED_REG] = show(hse_pkg::COL_GRN, hse_pkg::PAT_STEADY);

    if (sb_port_short)
      sel[hse_pkg::LED_SBP] = show(hse_pkg::COL_RED, hse_pkg::PAT_STEADY);
    else if (sb_port_in)
      sel[hse_pkg::LED_SBP] = show(hse_pkg::COL_ORG, hse_pkg::PAT_STEADY);
  end

  hse_blink_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_blink (
    .clk    (clk),
    .rst_n  (rst_n),
    .fast_q (fast_ph),
    .slow_q (slow_ph)
  );

  // Every LED shares one phase source, so pairing flashes stay in step.
  for (genvar g = 0; g < NL; g++)
  begin : g_led
    hse_led_drive u_drv (
      .clk     (clk),
      .rst_n   (rst_n),
      .colour  (sel[g][1:0]),
      .pattern (hse_pkg::hse_pat_e'(sel[g][3:2])),
      .fast_ph (fast_ph),
      .slow_ph (slow_ph),
      .grn_q   (led_grn[g]),
      .red_q   (led_red[g])
    );
  end

  // Read data is captured in the setup cycle so prdata is a flop.
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign pready = psel && penable;
  assign hit    = (paddr == hse_pkg::OFS_CTRL) ||
                  (paddr == hse_pkg::OFS_STAT) ||
                  (paddr == hse_pkg::OFS_MASK) ||
                  (paddr == hse_pkg::OFS_LEDS);

  always_comb
  begin
    flt = '0;
    flt[hse_pkg::EVT_SUP_ABN]   = supply_present && supply_abnormal;
    flt[hse_pkg::EVT_IN_SHORT]  = input_short;
    flt[hse_pkg::EVT_OUT_SHORT] = output_short;
    flt[hse_pkg::EVT_COMP_FAIL] = component_fail;
    flt[hse_pkg::EVT_VLV_SHORT] = valve_short;
    flt[hse_pkg::EVT_REG_SHORT] = reg_short;
    flt[hse_pkg::EVT_REG_ERR]   = reg_err && !sw_mode;
    flt[hse_pkg::EVT_SBP_SHORT] = sb_port_short;

    ctrl_d = ctrl_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr && paddr == hse_pkg::OFS_CTRL)
      ctrl_d = pwdata & 32'h0000_0001;
    if (wr && paddr == hse_pkg::OFS_MASK)
      mask_d = pwdata[7:0];
    if (wr && paddr == hse_pkg::OFS_STAT)
      stat_d = stat_q & ~pwdata[7:0];
    // A new fault wins over a clear in the same cycle.
    stat_d = stat_d | (flt & ~flt_q);
    irq_d  = |(stat_d & mask_d);

    rdata_d  = prdata;
    slverr_d = pslverr;
    if (setup)
    begin
      rdata_d  = 32'h0000_0000;
      slverr_d = !hit;
      case (paddr)
        hse_pkg::OFS_CTRL: rdata_d = ctrl_q;
        hse_pkg::OFS_STAT: rdata_d[7:0] = stat_q;
        hse_pkg::OFS_MASK: rdata_d[7:0] = mask_q;
        hse_pkg::OFS_LEDS:
        begin
          rdata_d[hse_pkg::LEDS_GRN_LSB +: NL] = led_grn;
          rdata_d[hse_pkg::LEDS_RED_LSB +: NL] = led_red;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_q    <= hse_pkg::OP_INIT;
      ctrl_q  <= hse_pkg::CTRL_RST;
      mask_q  <= hse_pkg::EVT_RST;
      stat_q  <= hse_pkg::EVT_RST;
      flt_q   <= hse_pkg::EVT_RST;
      irq     <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      op_q    <= op_d;
      ctrl_q  <= ctrl_d;
      mask_q  <= mask_d;
      stat_q  <= stat_d;
      flt_q   <= flt;
      irq     <= irq_d;
      prdata  <= rdata_d;
      pslverr <= slverr_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_pair_hold;
    (remote_type && pairing && !component_fail) [*2];
  endsequence
  chk_supply_off: assert property (
    !supply_present |=> !led_grn[hse_pkg::LED_SUP] &&
                        !led_red[hse_pkg::LED_SUP])
    else $error("supply LED lit without supply");
  chk_supply_good: assert property (
    supply_present && !supply_abnormal |=> led_grn[hse_pkg::LED_SUP])
    else $error("supply LED not steady green");
  chk_op_standby: assert property (
    op_q == hse_pkg::OP_STANDBY |=>
      led_grn[hse_pkg::LED_OP] && led_red[hse_pkg::LED_OP])
    else $error("standby mode not steady orange");
  chk_input_both: assert property (
    standby_in && isolation_in && !input_short |=>
      led_grn[hse_pkg::LED_INP] && led_red[hse_pkg::LED_INP])
    else $error("both inputs not steady orange");
  chk_eth_idle: assert property (
    eth_link[0] && !eth_act[0] |=> led_grn[hse_pkg::LED_ETH0])
    else $error("idle link not steady green");
  chk_sys_fail: assert property (
    remote_type && component_fail |=>
      led_red[hse_pkg::LED_SYS] && !led_grn[hse_pkg::LED_SYS])
    else $error("failure not steady red");
  chk_pair_phase: assert property (
    s_pair_hold |-> led_red[hse_pkg::LED_SYS] == led_red[hse_pkg::LED_SAW])
    else $error("pairing flashes out of phase");
  chk_reg_short: assert property (
    reg_short |=> led_red[hse_pkg::LED_REG] && !led_grn[hse_pkg::LED_REG])
    else $error("regulator short not steady red");
  chk_reg_switch: assert property (
    sw_mode && !reg_short && !regulator_switched_output |=>
      !led_grn[hse_pkg::LED_REG] && !led_red[hse_pkg::LED_REG])
    else $error("switched output off but LED lit");
  chk_sbp_short: assert property (
    sb_port_short |=> led_red[hse_pkg::LED_SBP] && !led_grn[hse_pkg::LED_SBP])
    else $error("standby port short not steady red");
  chk_irq_level: assert property (
    (stat_q & mask_q) != 8'h00 && !wr |=> irq)
    else $error("unmasked event without interrupt");

endmodule
